// file: hdl/adc_config_word_decode.sv
// serial setup word loader and decoder for the converter
`timescale 1ns/1ps
module adc_config_word_decode (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic config_serial_clock_i,
  input wire logic config_start_i,
  input wire logic config_serial_data_i,
  input wire logic clock_invert_sel_i,
  output logic [1:0] range_sel_o,
  output logic sleep_request_o,
  output logic [1:0] sample_mode_o,
  output logic output_code_sel_o,
  output logic word_loaded_o
);
  // ****************************************
  // link side: shifting on the port clock
  // ****************************************
  logic inv_meta_reg;
  logic inv_meta_next;
  logic inv_sync_reg;
  logic inv_sync_next;
  logic busy_reg;
  logic busy_next;
  logic [adc_cfg_pkg::BITS_W-1:0] cnt_reg;
  logic [adc_cfg_pkg::BITS_W-1:0] cnt_next;
  logic [adc_cfg_pkg::WORD_W-1:0] shift_reg;
  logic [adc_cfg_pkg::WORD_W-1:0] shift_next;
  logic [adc_cfg_pkg::WORD_W-1:0] hold_reg;
  logic [adc_cfg_pkg::WORD_W-1:0] hold_next;
  logic done_tgl_reg;
  logic done_tgl_next;

  always_comb begin
    inv_meta_next = clock_invert_sel_i;
    inv_sync_next = inv_meta_reg;
    busy_next = busy_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    hold_next = hold_reg;
    done_tgl_next = done_tgl_reg;
    // load opens on edge with start high and synced invert select low
    if (!busy_reg && config_start_i && !inv_sync_reg) begin
      busy_next = 1'b1;
      cnt_next = '0;
    end else if (busy_reg) begin
      // msb first into the shift register
      shift_next = {shift_reg[adc_cfg_pkg::WORD_W-2:0], config_serial_data_i};
      cnt_next = cnt_reg + 1'b1;
      if (cnt_reg == adc_cfg_pkg::LAST_BIT) begin
        busy_next = 1'b0;
        hold_next = {shift_reg[adc_cfg_pkg::WORD_W-2:0], config_serial_data_i};
        // toggle is the event; hold stays put until the next word ends
        done_tgl_next = ~done_tgl_reg;
      end
    end
  end

  always_ff @(posedge config_serial_clock_i or posedge rst_i) begin
    if (rst_i) begin
      inv_meta_reg <= 1'b0;
      inv_sync_reg <= 1'b0;
      busy_reg <= 1'b0;
      cnt_reg <= '0;
      shift_reg <= adc_cfg_pkg::WORD_RESET;
      hold_reg <= adc_cfg_pkg::WORD_RESET;
      done_tgl_reg <= 1'b0;
    end else begin
      inv_meta_reg <= inv_meta_next;
      inv_sync_reg <= inv_sync_next;
      busy_reg <= busy_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      hold_reg <= hold_next;
      done_tgl_reg <= done_tgl_next;
    end
  end

  // ****************************************
  // core side: crossing and decode
  // ****************************************
  logic tgl_meta_reg;
  logic tgl_sync_reg;
  logic tgl_seen_reg;
  logic tgl_meta_next;
  logic tgl_sync_next;
  logic tgl_seen_next;
  logic new_word;
  logic [1:0] range_reg;
  logic [1:0] range_next;
  logic sleep_reg;
  logic sleep_next;
  logic [1:0] mode_reg;
  logic [1:0] mode_next;
  logic code_reg;
  logic code_next;
  logic loaded_reg;
  logic loaded_next;

  always_comb begin
    tgl_meta_next = done_tgl_reg;
    tgl_sync_next = tgl_meta_reg;
    tgl_seen_next = tgl_sync_reg;
    new_word = tgl_sync_reg ^ tgl_seen_reg;
    range_next = range_reg;
    sleep_next = sleep_reg;
    mode_next = mode_reg;
    code_next = code_reg;
    loaded_next = new_word;
    // hold word updates on the same port edge as the toggle, two core clock edges before it is seen
    if (new_word) begin
      range_next = adc_cfg_pkg::decode_range(hold_reg[adc_cfg_pkg::BIPOLAR_BIT],
                                             hold_reg[adc_cfg_pkg::WIDE_RANGE_BIT]);
      // sleep follows bit 5; loads never gated by it
      sleep_next = hold_reg[adc_cfg_pkg::SLEEP_BIT];
      mode_next = adc_cfg_pkg::decode_mode(hold_reg[adc_cfg_pkg::WARP_BIT],
                                           hold_reg[adc_cfg_pkg::IMPULSE_BIT]);
      code_next = hold_reg[adc_cfg_pkg::CODE_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tgl_meta_reg <= 1'b0;
      tgl_sync_reg <= 1'b0;
      tgl_seen_reg <= 1'b0;
      range_reg <= adc_cfg_pkg::RANGE_UNI_5;
      sleep_reg <= 1'b0;
      mode_reg <= adc_cfg_pkg::MODE_NORMAL;
      code_reg <= 1'b0;
      loaded_reg <= 1'b0;
    end else begin
      tgl_meta_reg <= tgl_meta_next;
      tgl_sync_reg <= tgl_sync_next;
      tgl_seen_reg <= tgl_seen_next;
      range_reg <= range_next;
      sleep_reg <= sleep_next;
      mode_reg <= mode_next;
      code_reg <= code_next;
      loaded_reg <= loaded_next;
    end
  end

  assign range_sel_o = range_reg;
  assign sleep_request_o = sleep_reg;
  assign sample_mode_o = mode_reg;
  assign output_code_sel_o = code_reg;
  assign word_loaded_o = loaded_reg;
endmodule : adc_config_word_decode

// file: include/adc_cfg_pkg.sv
// constants and types for the converter setup word decoder
// Functional notes
// - bits 7:6 pick the bipolar and wide input ranges
// - bit 5 high puts converter in sleep
// - port keeps loading words while asleep
// - bits 4:3 pick normal, impulse or warp
// - bit 2 low twos complement, high binary
// - both range bits low gives 0 to 5 V
// - with invert select low, load starts first rising edge after start
package adc_cfg_pkg;
  // ****************************************
  // word layout
  // ****************************************
  localparam int WORD_W = 8;
  localparam int BITS_W = 3;
  localparam int BIPOLAR_BIT = 7;
  localparam int WIDE_RANGE_BIT = 6;
  localparam int SLEEP_BIT = 5;
  localparam int IMPULSE_BIT = 4;
  localparam int WARP_BIT = 3;
  localparam int CODE_BIT = 2;
  localparam int SPARE_BIT = 1;
  localparam logic [BITS_W-1:0] LAST_BIT = 3'h7;
  localparam logic [WORD_W-1:0] WORD_RESET = 8'h00;

  // ****************************************
  // decoded settings
  // ****************************************
  typedef enum logic [1:0] {
    RANGE_UNI_5,
    RANGE_UNI_10,
    RANGE_BI_5,
    RANGE_BI_10
  } range_t;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_IMPULSE,
    MODE_WARP
  } sample_mode_t;

  function automatic sample_mode_t decode_mode(input logic warp, input logic impulse);
    sample_mode_t m;
    m = MODE_NORMAL;
    if (warp && !impulse) begin
      m = MODE_WARP;
    end else if (impulse && !warp) begin
      m = MODE_IMPULSE;
    end
    return m;
  endfunction : decode_mode

  function automatic range_t decode_range(input logic bipolar, input logic wide);
    range_t r;
    // zero code is the 0 to 5 V range
    r = RANGE_UNI_5;
    // range from bits 7 and 6
    case ({bipolar, wide})
      2'b01: r = RANGE_UNI_10;
      2'b10: r = RANGE_BI_5;
      2'b11: r = RANGE_BI_10;
      default: r = RANGE_UNI_5;
    endcase
    return r;
  endfunction : decode_range
endpackage : adc_cfg_pkg

// file: tb/adc_cfg_assertions.sv
// checker for the decoded setup outputs
`timescale 1ns/1ps
module adc_cfg_assertions (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [1:0] range_sel_o,
  input wire logic sleep_request_o,
  input wire logic [1:0] sample_mode_o,
  input wire logic output_code_sel_o,
  input wire logic word_loaded_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  range_on_load_a: assert property ($changed(range_sel_o) |-> word_loaded_o)
    else $error("range moved without a load");
  sleep_on_load_a: assert property ($changed(sleep_request_o) |-> word_loaded_o)
    else $error("sleep moved without a load");
  mode_on_load_a: assert property ($changed(sample_mode_o) |-> word_loaded_o)
    else $error("mode moved without a load");
  mode_code_a: assert property (sample_mode_o != 2'h3)
    else $error("unused mode code");
  code_on_load_a: assert property ($changed(output_code_sel_o) |-> word_loaded_o)
    else $error("code format moved without a load");
  reset_range_a: assert property (disable iff (1'b0) $fell(rst_i) |-> range_sel_o == 2'h0)
    else $error("range not zero after reset");
  load_pulse_a: assert property (word_loaded_o |=> !word_loaded_o)
    else $error("load pulse too long");
  cover property (word_loaded_o && sleep_request_o);
  cover property (word_loaded_o && sample_mode_o == 2'h2);
  cover property (word_loaded_o && range_sel_o == 2'h3);
endmodule : adc_cfg_assertions
bind adc_config_word_decode adc_cfg_assertions chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
  .range_sel_o(range_sel_o), .sleep_request_o(sleep_request_o),
  .sample_mode_o(sample_mode_o), .output_code_sel_o(output_code_sel_o),
  .word_loaded_o(word_loaded_o));

// file: tb/cfg_host_model.sv
// host side of the serial setup port
`timescale 1ns/1ps
module cfg_host_model (
  output logic sclk_o,
  output logic start_o,
  output logic sdata_o
);
  initial begin
    sclk_o = 1'b0;
    start_o = 1'b0;
    sdata_o = 1'b0;
  end
  task automatic send(input logic [7:0] w);
    // two lead edges let the invert sync settle; clock idles low between frames
    for (int i = 10; i >= 0; i--) begin
      start_o = (i == 8);
      sdata_o = (i < 8) ? w[i] : ~sdata_o;
      #32 sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
    end
    sdata_o = ~w[0];
  endtask : send
endmodule : cfg_host_model

// file: tb/tb_top.sv
// directed bench for the setup word decoder
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin mismatches++; \
  $display("Error %0t: value mismatch", $time); end end
module tb_top;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, clock_invert_sel_i = 1'b0, got;
  logic sclk, start, sdata, sleep_request_o, output_code_sel_o, word_loaded_o;
  logic [1:0] range_sel_o, sample_mode_o, m;
  logic [7:0] words [5] = '{8'h00, 8'h6a, 8'hb6, 8'hdc, 8'h01};
  int mismatches = 0, cmp_count = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  cfg_host_model host (.sclk_o(sclk), .start_o(start), .sdata_o(sdata));
  adc_config_word_decode dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .config_serial_clock_i(sclk), .config_start_i(start), .config_serial_data_i(sdata),
    .clock_invert_sel_i(clock_invert_sel_i), .range_sel_o(range_sel_o),
    .sleep_request_o(sleep_request_o), .sample_mode_o(sample_mode_o),
    .output_code_sel_o(output_code_sel_o), .word_loaded_o(word_loaded_o));
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic load(input logic [7:0] w);
    got = 1'b0;
    host.send(w);
    for (int i = 0; i < 60 && !got; i++) begin
      @(posedge ref_clk_i) #1;
      got = word_loaded_o;
    end
  endtask : load
  initial begin
    repeat (12) @(posedge ref_clk_i);
    #1 rst_i = 1'b0;
    `CHK(range_sel_o, 2'h0)
    `CHK(sleep_request_o, 1'b0)
    `CHK(sample_mode_o, 2'h0)
    `CHK(output_code_sel_o, 1'b0)
    `CHK(word_loaded_o, 1'b0)
    foreach (words[k]) begin
      load(words[k]);
      if (got !== 1'b1) begin
        mismatches++;
        $display("Error %0t: no load pulse", $time);
        print_verdict();
      end
      m = (words[k][4:3] == 2'h1) ? 2'h2 : (words[k][4:3] == 2'h2) ? 2'h1 : 2'h0;
      `CHK(range_sel_o, words[k][7:6])
      `CHK(sleep_request_o, words[k][5])
      `CHK(sample_mode_o, m)
      `CHK(output_code_sel_o, words[k][2])
    end
    @(posedge ref_clk_i) #1 clock_invert_sel_i = 1'b1;
    // refused word differs in every field from the standing settings
    load(8'hec);
    `CHK(got, 1'b0)
    `CHK(output_code_sel_o, 1'b0)
    `CHK(range_sel_o, 2'h0)
    `CHK(sleep_request_o, 1'b0)
    `CHK(sample_mode_o, 2'h0)
    print_verdict();
  end
endmodule : tb_top
